// ---- dv/iepb_chk.sv ----
`timescale 1ns/100ps
module iepb_chk
  import iepb_pkg::*;
(
  input wire logic                          SYS_CLK_I,
  input wire logic                          SRST_I,
  input wire logic                          S_AXI_AWVALID_I,
  input wire logic                          S_AXI_AWREADY_O,
  input wire logic                          S_AXI_WVALID_I,
  input wire logic                          S_AXI_WREADY_O,
  input wire logic                          S_AXI_BVALID_O,
  input wire logic                          S_AXI_BREADY_I,
  input wire logic                          S_AXI_ARVALID_I,
  input wire logic                          S_AXI_ARREADY_O,
  input wire logic                          S_AXI_RVALID_O,
  input wire logic                          S_AXI_RREADY_I,
  input wire logic [DATA_W-1:0]             S_AXI_RDATA_O,
  input wire logic [N_EN_SRC-1:0]           EN_SRC_FLAG_I,
  input wire logic [N_EN_SRC-1:0]           EN_SRC_PRIO_OK_I,
  input wire logic [N_EN_SRC-1:0]           EN_SRC_REQ_O,
  input wire logic [N_PRIO_SRC-1:0]         PRIO_SRC_FLAG_I,
  input wire logic [N_PRIO_SRC-1:0]         PRIO_SRC_ENABLE_I,
  input wire logic [N_PRIO_SRC-1:0]         PRIO_SRC_REQ_O,
  input wire logic [N_PRIO_SRC*PRIO_W-1:0]  PRIO_SRC_LEVEL_O,
  input wire logic [PRIO_W-1:0]             EXTERNAL_IRQ0_PRIORITY_O,
  input wire logic                          CHARGE_TIME_UNIT_IRQ_ENABLE_O,
  input wire logic                          IRQ_O
);
  logic [N_PRIO_SRC-1:0] lvl_nz;

  always_comb begin
    for (int i = 0; i < N_PRIO_SRC; i++) begin
      lvl_nz[i] = |PRIO_SRC_LEVEL_O[i*PRIO_W +: PRIO_W];
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_wr_take;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_ar_take;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence

  property p_pri_rst;
    $fell(SRST_I) |-> PRIO_SRC_LEVEL_O == {N_PRIO_SRC{PRIO_LVL4}};
  endproperty
  property p_en_rst;
    $fell(SRST_I) |-> !CHARGE_TIME_UNIT_IRQ_ENABLE_O && EN_SRC_REQ_O == '0 && !IRQ_O;
  endproperty
  property p_en_req;
    !$past(SRST_I) |-> EN_SRC_REQ_O[4] ==
      $past(EN_SRC_FLAG_I[4] && EN_SRC_PRIO_OK_I[4] && CHARGE_TIME_UNIT_IRQ_ENABLE_O);
  endproperty
  // A zero level must veto the request even with flag and enable up
  property p_pri_req;
    !$past(SRST_I) |->
      PRIO_SRC_REQ_O == $past(PRIO_SRC_FLAG_I & PRIO_SRC_ENABLE_I & lvl_nz);
  endproperty
  property p_lvl_map;
    PRIO_SRC_LEVEL_O[2:0] == EXTERNAL_IRQ0_PRIORITY_O;
  endproperty
  property p_wr_resp;
    s_wr_take |-> ##[1:2] S_AXI_BVALID_O;
  endproperty
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O;
  endproperty
  property p_rd_lat;
    s_ar_take |=> S_AXI_RVALID_O;
  endproperty
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty

  a_pri_rst: assert property (p_pri_rst)
    else $error("priority fields not at level four after reset");
  a_en_rst: assert property (p_en_rst)
    else $error("enables or requests not clear after reset");
  a_en_req: assert property (p_en_req)
    else $error("enable gated request wrong");
  a_pri_req: assert property (p_pri_req)
    else $error("priority gated request wrong");
  a_lvl_map: assert property (p_lvl_map)
    else $error("level vector and priority port differ");
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before ready");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
endmodule

// ---- dv/iepb_src_model.sv ----
`timescale 1ns/100ps
module iepb_src_model
  import iepb_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [N_EN_SRC-1:0]   en_raise_i,
  input  wire logic [N_PRIO_SRC-1:0] pr_raise_i,
  output logic      [N_EN_SRC-1:0]   en_flag_o,
  output logic      [N_PRIO_SRC-1:0] pr_flag_o
);
  // Peripheral flags are levels, launched from the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_flag_o <= '0;
      pr_flag_o <= '0;
    end else begin
      en_flag_o <= en_raise_i;
      pr_flag_o <= pr_raise_i;
    end
  end
endmodule

// ---- dv/tb_interrupt_enable_priority_bank.sv ----
`timescale 1ns/100ps
module tb_interrupt_enable_priority_bank
  import iepb_pkg::*;
;
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} iepb_row_t;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, slow = 0;
  logic [7:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, d;
  logic [1:0]  r;
  logic [16:0] en_raise = '0, en_ok = '0;
  logic [10:0] pr_raise = '0, pr_en = '0;
  logic [15:0] sh [5];
  wire         awr, wrd, bv, arr, rv, irq;
  wire [1:0]   brsp, rrsp;
  wire [31:0]  rdat;
  wire [16:0]  en_flag, en_req, en_v;
  wire [10:0]  pr_flag, pr_req;
  wire [32:0]  lvl, pr_v;
  int          num_errors = 0, comparisons = 0, cyc = 0;
  iepb_row_t   rows [8] = '{
    '{OFF_ENA4, 16'h2000, 16'h2000}, '{OFF_ENA4, 16'hffff, 16'h210e},
    '{OFF_ENA5, 16'h2001, 16'h2000}, '{OFF_ENA5, 16'hffff, 16'h3fbe},
    '{OFF_PRI0, 16'h7001, 16'h7001}, '{OFF_PRI1, 16'hffff, 16'h7770},
    '{OFF_PRI2, 16'h0123, 16'h0123}, '{OFF_PRI0, 16'hffff, 16'h7777}};

  always #20 clk = ~clk;

  iepb_top i_dut (
    .SYS_CLK_I(clk), .SRST_I(rst), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_BRESP_O(brsp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARPROT_I(3'h0), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rrsp), .EN_SRC_FLAG_I(en_flag), .EN_SRC_PRIO_OK_I(en_ok),
    .PRIO_SRC_FLAG_I(pr_flag), .PRIO_SRC_ENABLE_I(pr_en), .EN_SRC_REQ_O(en_req),
    .PRIO_SRC_REQ_O(pr_req), .PRIO_SRC_LEVEL_O(lvl), .IRQ_O(irq),
    .SERIAL1_ERROR_IRQ_ENABLE_O(en_v[0]), .SERIAL2_ERROR_IRQ_ENABLE_O(en_v[1]),
    .CRC_GENERATOR_IRQ_ENABLE_O(en_v[2]), .LOW_VOLTAGE_DETECT_IRQ_ENABLE_O(en_v[3]),
    .CHARGE_TIME_UNIT_IRQ_ENABLE_O(en_v[4]), .SERIAL3_ERROR_IRQ_ENABLE_O(en_v[5]),
    .SERIAL3_RECEIVE_IRQ_ENABLE_O(en_v[6]), .SERIAL3_TRANSMIT_IRQ_ENABLE_O(en_v[7]),
    .I2C_PORT3_SLAVE_IRQ_ENABLE_O(en_v[8]), .I2C_PORT3_MASTER_IRQ_ENABLE_O(en_v[9]),
    .SERIAL4_ERROR_IRQ_ENABLE_O(en_v[10]), .SERIAL4_RECEIVE_IRQ_ENABLE_O(en_v[11]),
    .SERIAL4_TRANSMIT_IRQ_ENABLE_O(en_v[12]), .SPI_PORT3_FAULT_IRQ_ENABLE_O(en_v[13]),
    .SPI_PORT3_EVENT_IRQ_ENABLE_O(en_v[14]), .COMPARE9_IRQ_ENABLE_O(en_v[15]),
    .CAPTURE9_IRQ_ENABLE_O(en_v[16]), .EXTERNAL_IRQ0_PRIORITY_O(pr_v[2:0]),
    .CAPTURE1_PRIORITY_O(pr_v[5:3]), .COMPARE1_PRIORITY_O(pr_v[8:6]),
    .TIMER1_PRIORITY_O(pr_v[11:9]), .CAPTURE2_PRIORITY_O(pr_v[14:12]),
    .COMPARE2_PRIORITY_O(pr_v[17:15]), .TIMER2_PRIORITY_O(pr_v[20:18]),
    .TIMER3_PRIORITY_O(pr_v[23:21]), .SPI_PORT1_FAULT_PRIORITY_O(pr_v[26:24]),
    .SPI_PORT1_EVENT_PRIORITY_O(pr_v[29:27]), .SERIAL1_RECEIVE_PRIORITY_O(pr_v[32:30]));

  iepb_src_model i_src (.clk_i(clk), .rst_i(rst), .en_raise_i(en_raise),
    .pr_raise_i(pr_raise), .en_flag_o(en_flag), .pr_flag_o(pr_flag));

  function automatic logic [16:0] en_exp();
    return {sh[1][13:7], sh[1][5:1], sh[0][13], sh[0][8], sh[0][3:1]};
  endfunction

  function automatic logic [32:0] pr_exp();
    return {sh[4][14:12], sh[4][10:8], sh[4][6:4], sh[4][2:0], sh[3][14:12], sh[3][10:8],
            sh[3][6:4], sh[2][14:12], sh[2][10:8], sh[2][6:4], sh[2][2:0]};
  endfunction

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  // Ready is sampled at the falling edge, where it already equals the next rising-edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic ta, tw, tb;
    tb = 0;
    @(posedge clk);
    awv <= 1; awa <= a; wv <= 1; wd <= dv; bry <= !slow;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv && bry;
      rs = brsp;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (bv) bry <= !tb;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    logic ta, tr;
    tr = 0;
    @(posedge clk);
    arv <= 1; ara <= a; rry <= !slow;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv && rry;
      dv = rdat;
      rs = rrsp;
      @(posedge clk);
      if (ta) arv <= 0;
      if (rv) rry <= !tr;
    end
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    sh = '{16'h0000, 16'h0000, 16'h4444, 16'h4440, 16'h4444};
    for (int k = 0; k < 5; k++) begin
      rd(8'(k * 4), d, r);
      chk("reset value", sh[k], d);
    end
    chk("reset levels", pr_exp(), lvl);
    foreach (rows[i]) begin
      wr(rows[i].a, {16'h0000, rows[i].w}, r);
      sh[rows[i].a[4:2]] = rows[i].e;
      rd(rows[i].a, d, r);
      chk("readback", {RESP_OKAY, 16'h0, rows[i].e}, {r, d});
      chk("enable ports", en_exp(), en_v);
      chk("level vector", pr_exp(), lvl);
      chk("priority ports", pr_exp(), pr_v);
    end
    // Late ready on both channels exercises the hold checks
    slow = 1;
    wr(8'h40, 32'hffff_ffff, r);
    chk("unmapped write", RESP_SLVERR, r);
    rd(8'h40, d, r);
    chk("unmapped read", {RESP_SLVERR, 32'h0}, {r, d});
    slow = 0;
    en_ok <= '1;
    pr_en <= '1;
    en_raise <= '1;
    pr_raise <= '1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("enable requests", 17'h1ffff, en_req);
    chk("priority requests", 11'h3ff, pr_req);
    @(posedge clk);
    pr_en[0] <= 0;
    en_ok[16] <= 0;
    wr(OFF_ENA4, 32'h0, r);
    @(negedge clk);
    chk("gated enable requests", 17'h0ffe0, en_req);
    chk("gated priority requests", 11'h3fe, pr_req);
    chk("irq while masked", 1'b0, irq);
    rd(OFF_STAT, d, r);
    chk("status", 32'h07ff_ffff, d);
    wr(OFF_MASK, 32'h1, r);
    @(negedge clk);
    chk("irq raised", 1'b1, irq);
    wr(OFF_STAT, 32'h1, r);
    @(negedge clk);
    chk("irq cleared", 1'b0, irq);
    rd(OFF_STAT, d, r);
    chk("status after clear", 32'h07ff_fffe, d);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(OFF_PRI2, d, r);
    chk("priority after reset", 16'h4444, d);
    rd(OFF_ENA5, d, r);
    chk("enable after reset", 16'h0000, d);
    close_out();
  end
endmodule

bind iepb_top iepb_chk i_chk (.*);

// ---- verilog/iepb_axil_slave.sv ----
`timescale 1ns/100ps
module iepb_axil_slave
  import iepb_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [3:0]        wstrb_i,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  output logic [1:0]             bresp_o,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  input  wire logic [ADDR_W-1:0] araddr_i,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   wr_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [DATA_W-1:0]      wr_data_o,
  output logic [3:0]             wr_strb_o,
  input  wire logic              wr_err_i,
  output logic                   rd_o,
  output logic [ADDR_W-1:0]      rd_addr_o,
  input  wire logic [DATA_W-1:0] rd_data_i,
  input  wire logic              rd_err_i
);

  logic aw_full_r;
  logic w_full_r;

  // No new address or data while a response waits
  assign awready_o = !aw_full_r && !bvalid_o;
  assign wready_o  = !w_full_r && !bvalid_o;
  assign wr_o      = aw_full_r && w_full_r;
  assign arready_o = !rvalid_o;
  assign rd_o      = arvalid_i && arready_o;
  assign rd_addr_o = araddr_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_r <= 1'b0;
      wr_addr_o <= '0;
    end else if (awvalid_i && awready_o) begin
      aw_full_r <= 1'b1;
      wr_addr_o <= awaddr_i;
    end else if (wr_o) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_full_r  <= 1'b0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end else if (wvalid_i && wready_o) begin
      w_full_r  <= 1'b1;
      wr_data_o <= wdata_i;
      wr_strb_o <= wstrb_i;
    end else if (wr_o) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= RESP_OKAY;
    end else if (wr_o) begin
      bvalid_o <= 1'b1;
      bresp_o  <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= RESP_OKAY;
    end else if (rd_o) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_data_i;
      rresp_o  <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

endmodule

// ---- verilog/iepb_pkg.sv ----
package iepb_pkg;

  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 8;
  localparam int          WORD_W      = 16;
  localparam int          PRIO_W      = 3;
  localparam int          N_EN_SRC    = 17;
  localparam int          N_PRIO_SRC  = 11;
  localparam int          N_EVT       = N_EN_SRC + N_PRIO_SRC;
  localparam int          N_PWORD     = 3;

  // Byte addresses of the register map
  localparam logic [7:0]  OFF_ENA4    = 8'h00;
  localparam logic [7:0]  OFF_ENA5    = 8'h04;
  localparam logic [7:0]  OFF_PRI0    = 8'h08;
  localparam logic [7:0]  OFF_PRI1    = 8'h0c;
  localparam logic [7:0]  OFF_PRI2    = 8'h10;
  localparam logic [7:0]  OFF_STAT    = 8'h14;
  localparam logic [7:0]  OFF_MASK    = 8'h18;
  localparam logic [7:0]  OFF_REQ     = 8'h1c;

  // Implemented bits of each 16-bit word
  localparam logic [15:0] ENA4_IMPL   = 16'h210e;
  localparam logic [15:0] ENA5_IMPL   = 16'h3fbe;
  localparam logic [15:0] PRI0_IMPL   = 16'h7777;
  localparam logic [15:0] PRI1_IMPL   = 16'h7770;
  localparam logic [15:0] PRI2_IMPL   = 16'h7777;

  localparam logic [15:0] ENA_RST     = 16'h0000;
  localparam logic [15:0] PRI_RST     = 16'h4444;
  localparam logic [2:0]  PRIO_OFF    = 3'h0;
  localparam logic [2:0]  PRIO_LVL4   = 3'h4;

  // Enable sources 0..4 sit in word four, 5..16 in word five
  localparam int          N_EN4       = 5;
  localparam int          EN_BIT [N_EN_SRC] = '{1, 2, 3, 8, 13,
                                                 1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 12, 13};

  // Priority sources: word index and field low bit
  localparam int          PR_WORD [N_PRIO_SRC] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
  localparam int          PR_LSB  [N_PRIO_SRC] = '{0, 4, 8, 12, 4, 8, 12, 0, 4, 8, 12};

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    IEPB_W_IDLE = 2'b00,
    IEPB_W_HALF = 2'b01,
    IEPB_W_RESP = 2'b11
  } iepb_wstate_t;

endpackage

// ---- verilog/iepb_top.sv ----
// Contract
// - Enable one passes request, zero blocks
// - Unimplemented bits read zero, ignore writes
// - Priority code 111 is level seven
// - Code 001 is level one, binary order
// - Priority zero disables source regardless of enable
// - Priority fields reset to 100
// - Enable bits reset to zero
// - Word four: charge-time bit 13, low-voltage bit 8
// - Word four: CRC 3, serial2 error 2, serial1 error 1
// - Word five bits 13..8 capture9 to serial4 receive
// - Word five bits 7,5,4,3,2,1 as listed
// - Priority word zero field placement
// - Priority word one placement, bits 3-0 unused
// - Priority word two field placement
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module iepb_top
  import iepb_pkg::*;
(
  input  wire logic                   SYS_CLK_I,
  input  wire logic                   SRST_I,
  input  wire logic                   S_AXI_AWVALID_I,
  output logic                        S_AXI_AWREADY_O,
  input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR_I,
  input  wire logic [2:0]             S_AXI_AWPROT_I,
  input  wire logic                   S_AXI_WVALID_I,
  output logic                        S_AXI_WREADY_O,
  input  wire logic [DATA_W-1:0]      S_AXI_WDATA_I,
  input  wire logic [3:0]             S_AXI_WSTRB_I,
  output logic                        S_AXI_BVALID_O,
  input  wire logic                   S_AXI_BREADY_I,
  output logic [1:0]                  S_AXI_BRESP_O,
  input  wire logic                   S_AXI_ARVALID_I,
  output logic                        S_AXI_ARREADY_O,
  input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR_I,
  input  wire logic [2:0]             S_AXI_ARPROT_I,
  output logic                        S_AXI_RVALID_O,
  input  wire logic                   S_AXI_RREADY_I,
  output logic [DATA_W-1:0]           S_AXI_RDATA_O,
  output logic [1:0]                  S_AXI_RRESP_O,
  input  wire logic [N_EN_SRC-1:0]    EN_SRC_FLAG_I,
  input  wire logic [N_EN_SRC-1:0]    EN_SRC_PRIO_OK_I,
  input  wire logic [N_PRIO_SRC-1:0]  PRIO_SRC_FLAG_I,
  input  wire logic [N_PRIO_SRC-1:0]  PRIO_SRC_ENABLE_I,
  output logic [N_EN_SRC-1:0]         EN_SRC_REQ_O,
  output logic [N_PRIO_SRC-1:0]       PRIO_SRC_REQ_O,
  output logic [N_PRIO_SRC*PRIO_W-1:0] PRIO_SRC_LEVEL_O,
  output logic                        CHARGE_TIME_UNIT_IRQ_ENABLE_O,
  output logic                        LOW_VOLTAGE_DETECT_IRQ_ENABLE_O,
  output logic                        CRC_GENERATOR_IRQ_ENABLE_O,
  output logic                        SERIAL2_ERROR_IRQ_ENABLE_O,
  output logic                        SERIAL1_ERROR_IRQ_ENABLE_O,
  output logic                        CAPTURE9_IRQ_ENABLE_O,
  output logic                        COMPARE9_IRQ_ENABLE_O,
  output logic                        SPI_PORT3_EVENT_IRQ_ENABLE_O,
  output logic                        SPI_PORT3_FAULT_IRQ_ENABLE_O,
  output logic                        SERIAL4_TRANSMIT_IRQ_ENABLE_O,
  output logic                        SERIAL4_RECEIVE_IRQ_ENABLE_O,
  output logic                        SERIAL4_ERROR_IRQ_ENABLE_O,
  output logic                        I2C_PORT3_MASTER_IRQ_ENABLE_O,
  output logic                        I2C_PORT3_SLAVE_IRQ_ENABLE_O,
  output logic                        SERIAL3_TRANSMIT_IRQ_ENABLE_O,
  output logic                        SERIAL3_RECEIVE_IRQ_ENABLE_O,
  output logic                        SERIAL3_ERROR_IRQ_ENABLE_O,
  output logic [PRIO_W-1:0]           TIMER1_PRIORITY_O,
  output logic [PRIO_W-1:0]           COMPARE1_PRIORITY_O,
  output logic [PRIO_W-1:0]           CAPTURE1_PRIORITY_O,
  output logic [PRIO_W-1:0]           EXTERNAL_IRQ0_PRIORITY_O,
  output logic [PRIO_W-1:0]           TIMER2_PRIORITY_O,
  output logic [PRIO_W-1:0]           COMPARE2_PRIORITY_O,
  output logic [PRIO_W-1:0]           CAPTURE2_PRIORITY_O,
  output logic [PRIO_W-1:0]           SERIAL1_RECEIVE_PRIORITY_O,
  output logic [PRIO_W-1:0]           SPI_PORT1_EVENT_PRIORITY_O,
  output logic [PRIO_W-1:0]           SPI_PORT1_FAULT_PRIORITY_O,
  output logic [PRIO_W-1:0]           TIMER3_PRIORITY_O,
  output logic                        IRQ_O
);

  // Byte-lane merge restricted to the implemented bits of a word
  function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] old_val,
                                                   input logic [DATA_W-1:0] data,
                                                   input logic [3:0]        strb,
                                                   input logic [WORD_W-1:0] impl);
    logic [WORD_W-1:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    merge_word = ((old_val & ~lanes) | (data[WORD_W-1:0] & lanes)) & impl;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFF_ENA4, OFF_ENA5, OFF_PRI0, OFF_PRI1, OFF_PRI2,
      OFF_STAT, OFF_MASK, OFF_REQ: is_mapped = 1'b1;
      default:                     is_mapped = 1'b0;
    endcase
  endfunction

  logic                  wr;
  logic [ADDR_W-1:0]     wr_addr;
  logic [DATA_W-1:0]     wr_data;
  logic [3:0]            wr_strb;
  logic                  rd;
  logic [ADDR_W-1:0]     rd_addr;
  logic [DATA_W-1:0]     rd_data;
  logic [WORD_W-1:0]     ena4_r;
  logic [WORD_W-1:0]     ena5_r;
  logic [WORD_W-1:0]     pri_r [N_PWORD];
  logic [WORD_W-1:0]     pri_impl [N_PWORD];
  logic [N_EN_SRC-1:0]   en_bits;
  logic [PRIO_W-1:0]     level [N_PRIO_SRC];
  logic [N_EN_SRC-1:0]   en_req_nxt;
  logic [N_PRIO_SRC-1:0] pr_req_nxt;
  logic [N_EN_SRC-1:0]   en_req_r;
  logic [N_PRIO_SRC-1:0] pr_req_r;
  logic [N_EVT-1:0]      req_all;
  logic [N_EVT-1:0]      req_all_nxt;
  logic [N_EVT-1:0]      stat_r;
  logic [N_EVT-1:0]      stat_nxt;
  logic [N_EVT-1:0]      mask_r;
  logic [N_EVT-1:0]      evt;
  logic [N_EVT-1:0]      clr;

  // Protection type has no effect on this map
  iepb_axil_slave u_slave (
    .clk_i     (SYS_CLK_I),
    .rst_i     (SRST_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .awaddr_i  (S_AXI_AWADDR_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .bresp_o   (S_AXI_BRESP_O),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .araddr_i  (S_AXI_ARADDR_I),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .wr_o      (wr),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_err_i  (!is_mapped(wr_addr)),
    .rd_o      (rd),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (!is_mapped(rd_addr))
  );

  assign pri_impl[0] = PRI0_IMPL;
  assign pri_impl[1] = PRI1_IMPL;
  assign pri_impl[2] = PRI2_IMPL;

  // writes only land on implemented bits
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ena4_r <= ENA_RST;
    end else if (wr && wr_addr == OFF_ENA4) begin
      ena4_r <= merge_word(ena4_r, wr_data, wr_strb, ENA4_IMPL);
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ena5_r <= ENA_RST;
    end else if (wr && wr_addr == OFF_ENA5) begin
      ena5_r <= merge_word(ena5_r, wr_data, wr_strb, ENA5_IMPL);
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_PWORD; g = g + 1) begin : g_pword
      localparam logic [ADDR_W-1:0] OFF = OFF_PRI0 + ADDR_W'(4 * g);
      // every field resets to level four
      always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
          pri_r[g] <= PRI_RST & pri_impl[g];
        end else if (wr && wr_addr == OFF) begin
          pri_r[g] <= merge_word(pri_r[g], wr_data, wr_strb, pri_impl[g]);
        end
      end
    end

    // word four bits 13 and 8
    // word four bits 3, 2, 1
    // word five bits 13 down to 8
    // word five bits 7 and 5..1
    for (g = 0; g < N_EN_SRC; g = g + 1) begin : g_en
      if (g < N_EN4) begin : g_w4
        assign en_bits[g] = ena4_r[EN_BIT[g]];
      end else begin : g_w5
        assign en_bits[g] = ena5_r[EN_BIT[g]];
      end
      assign en_req_nxt[g] = EN_SRC_FLAG_I[g] && en_bits[g] && EN_SRC_PRIO_OK_I[g];
    end

    for (g = 0; g < N_PRIO_SRC; g = g + 1) begin : g_pr
      assign level[g] = pri_r[PR_WORD[g]][PR_LSB[g] +: PRIO_W];
      // code passed through, 111 is level seven
      // binary code is the level itself
      assign PRIO_SRC_LEVEL_O[g*PRIO_W +: PRIO_W] = level[g];
      assign pr_req_nxt[g] = PRIO_SRC_FLAG_I[g] && PRIO_SRC_ENABLE_I[g]
                             && (level[g] != PRIO_OFF);
    end
  endgenerate

  // Requests are registered so the arbiter sees clean levels
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      en_req_r <= '0;
      pr_req_r <= '0;
    end else begin
      en_req_r <= en_req_nxt;
      pr_req_r <= pr_req_nxt;
    end
  end

  assign EN_SRC_REQ_O   = en_req_r;
  assign PRIO_SRC_REQ_O = pr_req_r;

  // Newly presented request is the event
  assign req_all     = {pr_req_r, en_req_r};
  assign req_all_nxt = {pr_req_nxt, en_req_nxt};
  assign evt         = req_all_nxt & ~req_all;
  assign clr         = (wr && wr_addr == OFF_STAT) ? wr_data[N_EVT-1:0] : '0;
  // Set wins over a simultaneous write-one clear
  assign stat_nxt    = (stat_r & ~clr) | evt;

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      mask_r <= '0;
    end else if (wr && wr_addr == OFF_MASK) begin
      mask_r <= wr_data[N_EVT-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(stat_nxt & mask_r);
    end
  end

  // unmapped and unimplemented bits read zero
  always_comb begin
    rd_data = '0;
    case (rd_addr)
      OFF_ENA4: rd_data[WORD_W-1:0] = ena4_r;
      OFF_ENA5: rd_data[WORD_W-1:0] = ena5_r;
      OFF_PRI0: rd_data[WORD_W-1:0] = pri_r[0];
      OFF_PRI1: rd_data[WORD_W-1:0] = pri_r[1];
      OFF_PRI2: rd_data[WORD_W-1:0] = pri_r[2];
      OFF_STAT: rd_data[N_EVT-1:0]  = stat_r;
      OFF_MASK: rd_data[N_EVT-1:0]  = mask_r;
      OFF_REQ:  rd_data[N_EVT-1:0]  = req_all;
      default:  rd_data = '0;
    endcase
  end

  assign SERIAL1_ERROR_IRQ_ENABLE_O      = en_bits[0];
  assign SERIAL2_ERROR_IRQ_ENABLE_O      = en_bits[1];
  assign CRC_GENERATOR_IRQ_ENABLE_O      = en_bits[2];
  assign LOW_VOLTAGE_DETECT_IRQ_ENABLE_O = en_bits[3];
  assign CHARGE_TIME_UNIT_IRQ_ENABLE_O   = en_bits[4];
  assign SERIAL3_ERROR_IRQ_ENABLE_O      = en_bits[5];
  assign SERIAL3_RECEIVE_IRQ_ENABLE_O    = en_bits[6];
  assign SERIAL3_TRANSMIT_IRQ_ENABLE_O   = en_bits[7];
  assign I2C_PORT3_SLAVE_IRQ_ENABLE_O    = en_bits[8];
  assign I2C_PORT3_MASTER_IRQ_ENABLE_O   = en_bits[9];
  assign SERIAL4_ERROR_IRQ_ENABLE_O      = en_bits[10];
  assign SERIAL4_RECEIVE_IRQ_ENABLE_O    = en_bits[11];
  assign SERIAL4_TRANSMIT_IRQ_ENABLE_O   = en_bits[12];
  assign SPI_PORT3_FAULT_IRQ_ENABLE_O    = en_bits[13];
  assign SPI_PORT3_EVENT_IRQ_ENABLE_O    = en_bits[14];
  assign COMPARE9_IRQ_ENABLE_O           = en_bits[15];
  assign CAPTURE9_IRQ_ENABLE_O           = en_bits[16];

  assign EXTERNAL_IRQ0_PRIORITY_O    = level[0];
  assign CAPTURE1_PRIORITY_O         = level[1];
  assign COMPARE1_PRIORITY_O         = level[2];
  assign TIMER1_PRIORITY_O           = level[3];
  assign CAPTURE2_PRIORITY_O         = level[4];
  assign COMPARE2_PRIORITY_O         = level[5];
  assign TIMER2_PRIORITY_O           = level[6];
  assign TIMER3_PRIORITY_O           = level[7];
  assign SPI_PORT1_FAULT_PRIORITY_O  = level[8];
  assign SPI_PORT1_EVENT_PRIORITY_O  = level[9];
  assign SERIAL1_RECEIVE_PRIORITY_O  = level[10];

endmodule
